// >>> rtl/spbr_top.sv
/*
  single-port synchronous block memory, RAM or ROM, three write modes,
  port gate, output preset, optional input and output register stages,
  handshake flags.
  assumes user logic drives every input synchronously to sys_clk_in.
*/
`timescale 1ns/1ns
`include "spbr_defs.svh"

// Functional notes
// - everything except the asynchronous reset happens on the rising clock edge
// - closed gate holds output and blocks writes
// - write strobe stores data at addressed word
// - no write strobe reads addressed word out
// - ROM ignores write inputs, keeps initial contents
// - preset loads output register with preset value
// - preset spares memory and concurrent writes
// - preset only acts while gate open
// - data ports are vectors even one bit
// - write-first shows written data after latency
// - read-first shows old contents after latency
// - no-change holds output during writes
// - write-first default; others need advanced variant
// - ready is the gate registered, one edge late
// - valid follows new-address flag by latency
// - data width one to 256 bits
// - depth 2 up to variant maximum
// - address width covers every configured word
// - unset words power up at global value
// - default is read-write RAM, option ROM
// - new-address flag never touches memory access
// - one optional extra output register stage
module spbr_top
  import spbr_pkg::*;
#(
  parameter int unsigned       DATA_W     = `SPBR_DEF_W,
  parameter int unsigned       DEPTH      = `SPBR_DEF_DEPTH,
  parameter int unsigned       ADDR_W     = $clog2(DEPTH),
  parameter bit                ARCH_ADV   = 1'h1,
  parameter bit                IS_ROM     = 1'h0,
  parameter spbr_wmode_t       WRITE_MODE = SPBR_WRITE_FIRST,
  parameter bit                REG_INPUTS = 1'h0,
  parameter int unsigned       OUT_STAGES = 0,
  parameter logic [DATA_W-1:0] PRESET_VAL = '0,
  parameter logic [DATA_W-1:0] INIT_VAL   = '0
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              port_gate_in,
  input  wire logic              write_strobe_in,
  input  wire logic [DATA_W-1:0] write_data_bus_in,
  input  wire logic [ADDR_W-1:0] word_select_bus_in,
  input  wire logic              output_sync_preset_in,
  input  wire logic              new_address_valid_in,
  output logic      [DATA_W-1:0] read_data_bus_out,
  output logic                   accept_ready_out,
  output logic                   output_valid_out
);

  // ************************************************************
  // configuration checks
  // ************************************************************

  localparam int unsigned MAX_DEPTH =
    ARCH_ADV ? `SPBR_MAX_DEPTH_ADV : `SPBR_MAX_DEPTH_BASE;
  localparam int unsigned LAT =
    `SPBR_CORE_LAT + int'(REG_INPUTS) + OUT_STAGES;

  if (DATA_W < `SPBR_MIN_W || DATA_W > `SPBR_MAX_W) begin : g_bad_w
    $error("data width out of range");
  end
  if (DEPTH < `SPBR_MIN_DEPTH || DEPTH > MAX_DEPTH) begin : g_bad_depth
    $error("depth out of range");
  end
  if (ADDR_W != $clog2(DEPTH)) begin : g_bad_addr
    $error("address width does not match depth");
  end
  if (!ARCH_ADV && WRITE_MODE != SPBR_WRITE_FIRST) begin : g_bad_mode
    $error("base variant supports write-first only");
  end
  if (!ARCH_ADV && PRESET_VAL != '0) begin : g_bad_preset
    $error("base variant preset value must be zero");
  end
  if (OUT_STAGES > `SPBR_MAX_OUT_STAGES) begin : g_bad_stages
    $error("at most one extra output stage");
  end

  // ************************************************************
  // input stage
  // ************************************************************

  // input capture is gated too, so a closed gate freezes the pipe
  spbr_ctl_t         ctl_raw;
  spbr_ctl_t         a_ctl;
  logic [ADDR_W-1:0] a_addr;
  logic [DATA_W-1:0] a_din;

  // a ROM never sees the write inputs at all
  assign ctl_raw.we = write_strobe_in & ~IS_ROM;
  assign ctl_raw.nd = new_address_valid_in;

  if (REG_INPUTS) begin : g_in_reg
    spbr_ctl_t         ctl_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] din_ff;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        ctl_ff  <= '0;
        addr_ff <= '0;
        din_ff  <= '0;
      end else if (port_gate_in) begin
        ctl_ff  <= ctl_raw;
        addr_ff <= word_select_bus_in;
        din_ff  <= write_data_bus_in;
      end
    end

    assign a_ctl  = ctl_ff;
    assign a_addr = addr_ff;
    assign a_din  = din_ff;
  end else begin : g_in_wire
    assign a_ctl  = ctl_raw;
    assign a_addr = word_select_bus_in;
    assign a_din  = write_data_bus_in;
  end

  // ************************************************************
  // storage array
  // ************************************************************

  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [DEPTH-1:0]  word_hit;
  logic              wr_en;
  logic              addr_ok;
  logic [DATA_W-1:0] rd_word;

  // the new-address flag has no path into this section
  assign wr_en = port_gate_in & a_ctl.we;
  // a depth below a power of two leaves holes that read zero
  assign addr_ok = 32'(a_addr) < DEPTH;
  assign rd_word = addr_ok ? mem_ff[a_addr] : '0;

  // reset reloads the global value; the array has no other clear
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    assign word_hit[i] = wr_en & (32'(a_addr) == i);
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        mem_ff[i] <= INIT_VAL;
      end else if (word_hit[i]) begin
        mem_ff[i] <= a_din;
      end
    end
  end

  // ************************************************************
  // output latch and write modes
  // ************************************************************

  logic              core_load;
  logic              core_preset;
  logic [DATA_W-1:0] core_d;
  logic [DATA_W-1:0] core_q;
  logic [DATA_W-1:0] final_q;
  logic              is_wfirst;
  logic              is_nochg;

  assign is_wfirst = WRITE_MODE == SPBR_WRITE_FIRST;
  assign is_nochg  = WRITE_MODE == SPBR_NO_CHANGE;

  // preset only with the gate open; it never blocks the write
  assign core_preset = port_gate_in & output_sync_preset_in;
  assign core_load   = port_gate_in & ~(a_ctl.we & is_nochg);
  assign core_d      = (a_ctl.we & is_wfirst) ? a_din
                                              : rd_word;

  spbr_out_reg #(
    .DATA_W     (DATA_W),
    .PRESET_VAL (PRESET_VAL)
  ) u_core_reg (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .load_in    (core_load),
    .preset_in  (core_preset),
    .d_in       (core_d),
    .q_out      (core_q)
  );

  if (OUT_STAGES > 0) begin : g_out_stage
    spbr_out_reg #(
      .DATA_W     (DATA_W),
      .PRESET_VAL (PRESET_VAL)
    ) u_pipe_reg (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .load_in    (port_gate_in),
      .preset_in  (core_preset),
      .d_in       (core_q),
      .q_out      (final_q)
    );
  end else begin : g_no_stage
    assign final_q = core_q;
  end

  // bus shape kept even when DATA_W is one
  assign read_data_bus_out = final_q;

  // ************************************************************
  // handshake
  // ************************************************************

  logic ready_ff;

  // registered, so ready trails the gate by one edge
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_ff <= 1'h0;
    end else begin
      ready_ff <= port_gate_in;
    end
  end

  assign accept_ready_out = ready_ff;

  spbr_valid_pipe #(
    .LAT (LAT)
  ) u_valid (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .adv_in     (port_gate_in),
    .nd_in      (ctl_raw.nd),
    .valid_out  (output_valid_out)
  );

  // ************************************************************
  // checks
  // ************************************************************

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_GATE_HOLD: assert property (
    !port_gate_in |=> $stable(core_q)
  ) else $error("output latch moved with gate closed");

  AST_WRITE_STORE: assert property (
    wr_en && addr_ok |=> mem_ff[$past(a_addr)] == $past(a_din)
  ) else $error("write did not store data");

  AST_READ_OUT: assert property (
    port_gate_in && !a_ctl.we && !output_sync_preset_in
    |=> core_q == $past(rd_word)
  ) else $error("read did not present addressed word");

  AST_ROM_LOCK: assert property (
    IS_ROM |-> !wr_en
  ) else $error("write reached a read-only array");

  AST_PRESET_LOAD: assert property (
    port_gate_in && output_sync_preset_in |=> core_q == PRESET_VAL
  ) else $error("preset value not loaded");

  AST_PRESET_WRITE: assert property (
    core_preset && wr_en && addr_ok
    |=> mem_ff[$past(a_addr)] == $past(a_din)
  ) else $error("preset disturbed a write");

  AST_PRESET_GATED: assert property (
    !port_gate_in && output_sync_preset_in ##1 port_gate_in
    |-> core_q == $past(core_q)
  ) else $error("preset acted with gate closed");

  AST_WFIRST: assert property (
    is_wfirst && port_gate_in && a_ctl.we && !output_sync_preset_in
    |=> core_q == $past(a_din)
  ) else $error("write-first output wrong");

  AST_RFIRST: assert property (
    WRITE_MODE == SPBR_READ_FIRST && port_gate_in && a_ctl.we
    && !output_sync_preset_in |=> core_q == $past(rd_word)
  ) else $error("read-first output wrong");

  AST_NOCHG: assert property (
    is_nochg && port_gate_in && a_ctl.we && !output_sync_preset_in
    |=> $stable(core_q)
  ) else $error("no-change output moved on write");

  AST_READY: assert property (
    ##1 accept_ready_out == $past(port_gate_in)
  ) else $error("ready does not follow gate");

  AST_VALID_ONE: assert property (
    LAT == 1 && port_gate_in |=> output_valid_out == $past(ctl_raw.nd)
  ) else $error("valid lag wrong");

  // longer latencies spelled out per case; only gated edges move the pipe
  // so each case needs the gate open on every edge of the span
  AST_VALID_TWO: assert property (
    (LAT == 2 && port_gate_in) ##1 port_gate_in |=> output_valid_out == $past(ctl_raw.nd, 2)
  ) else $error("valid lag wrong at latency two");

  AST_VALID_THREE: assert property (
    (LAT == 3 && port_gate_in) ##1 port_gate_in [*2] |=> output_valid_out == $past(ctl_raw.nd, 3)
  ) else $error("valid lag wrong at latency three");

  AST_VALID_GATE: assert property (
    !port_gate_in |=> $stable(output_valid_out)
  ) else $error("valid moved with gate closed");

  AST_RDATA_HOLD: assert property (
    !port_gate_in |=> $stable(read_data_bus_out)
  ) else $error("read data moved with gate closed");

  AST_WRITE_BLOCK: assert property (
    !port_gate_in && addr_ok |=> mem_ff[$past(a_addr)] == $past(rd_word)
  ) else $error("array changed with gate closed");

  AST_PRESET_OUT: assert property (
    core_preset |=> read_data_bus_out == PRESET_VAL
  ) else $error("preset value not on read data");

  AST_PRESET_MEM: assert property (
    core_preset && !wr_en && addr_ok |=> mem_ff[$past(a_addr)] == $past(rd_word)
  ) else $error("preset disturbed the array");

  AST_ROM_HOLD: assert property (
    IS_ROM && addr_ok |=> mem_ff[$past(a_addr)] == $past(rd_word)
  ) else $error("read-only contents changed");

  AST_STAGE_MOVE: assert property (
    OUT_STAGES > 0 && port_gate_in && !output_sync_preset_in
    |=> read_data_bus_out == $past(core_q)
  ) else $error("extra output stage did not follow latch");

endmodule

// >>> rtl/spbr_defs.svh
/*
  constants of the single-port block memory: ranges, latencies, stage counts.
  assumes inclusion by bare name from every design file that needs them.
*/
`ifndef SPBR_DEFS_SVH
`define SPBR_DEFS_SVH

`define SPBR_MIN_W          1
`define SPBR_MAX_W          256
`define SPBR_MIN_DEPTH      2
`define SPBR_MAX_DEPTH_BASE 262144
`define SPBR_MAX_DEPTH_ADV  1048576
`define SPBR_MAX_OUT_STAGES 1
`define SPBR_CORE_LAT       1
`define SPBR_DEF_W          16
`define SPBR_DEF_DEPTH      256

`endif

// >>> rtl/spbr_pkg.sv
/*
  types of the single-port block memory: write modes and control carrier.
  assumes nothing beyond a SystemVerilog compiler.
*/
package spbr_pkg;

  typedef enum {
    SPBR_WRITE_FIRST,
    SPBR_READ_FIRST,
    SPBR_NO_CHANGE
  } spbr_wmode_t;

  typedef struct packed {
    logic we;
    logic nd;
  } spbr_ctl_t;

endpackage

// >>> rtl/spbr_out_reg.sv
/*
  one output register of the memory with synchronous preset and load.
  assumes the caller gates preset and load with the port gate.
*/
`timescale 1ns/1ns

module spbr_out_reg #(
  parameter int unsigned       DATA_W     = 16,
  parameter logic [DATA_W-1:0] PRESET_VAL = '0
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              load_in,
  input  wire logic              preset_in,
  input  wire logic [DATA_W-1:0] d_in,
  output logic      [DATA_W-1:0] q_out
);

  logic [DATA_W-1:0] q_ff;

  // preset outranks load so a held output is still forced
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_ff <= PRESET_VAL;
    end else if (preset_in) begin
      q_ff <= PRESET_VAL;
    end else if (load_in) begin
      q_ff <= d_in;
    end
  end

  assign q_out = q_ff;

endmodule

// >>> rtl/spbr_valid_pipe.sv
/*
  valid tracker: shifts the new-address flag through the read latency.
  assumes adv_in is high on the edges on which the data pipeline moves.
*/
`timescale 1ns/1ns
`include "spbr_defs.svh"

module spbr_valid_pipe #(
  parameter int unsigned LAT = 1
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  input  wire logic adv_in,
  input  wire logic nd_in,
  output logic      valid_out
);

  logic [LAT-1:0] vld_ff;
  logic [LAT:0]   vld_in;

  // a zero latency pipe has no stage to read the flag from
  if (LAT < `SPBR_CORE_LAT) begin : g_bad_lat
    $error("valid pipe needs at least one stage");
  end

  assign vld_in[0] = nd_in;

  for (genvar s = 0; s < LAT; s++) begin : g_stage
    assign vld_in[s+1] = vld_ff[s];
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        vld_ff[s] <= 1'h0;
      end else if (adv_in) begin
        vld_ff[s] <= vld_in[s];
      end
    end
  end

  assign valid_out = vld_ff[LAT-1];

endmodule

// >>> sim/spbr_user_model.sv
/*
  user-side request driver of the block memory port.
  assumes the bench calls drive once per access, in order.
*/
`timescale 1ns/1ns

module spbr_user_model (
  input  wire logic       sys_clk_in,
  output logic            gate_out,
  output logic            we_out,
  output logic [3:0]      addr_out,
  output logic [7:0]      data_out,
  output logic            preset_out,
  output logic            nd_out
);
  // ****************
  // request driver
  // ****************
  initial begin
    {gate_out, we_out, addr_out, data_out, preset_out, nd_out} = '0;
  end

  // closed gate: address and data lines toggle so a stale value cannot pass for a good one
  task automatic drive(input logic g, w, input logic [3:0] a, input logic [7:0] d,
                       input logic p, n);
    @(posedge sys_clk_in);
    gate_out   <= g;
    we_out     <= w;
    addr_out   <= g ? a : ~addr_out;
    data_out   <= g ? d : ~data_out;
    preset_out <= p;
    nd_out     <= n;
  endtask
endmodule

// >>> sim/test_single_port_sync_block_ram.sv
/*
  self-checking bench of the block memory in four builds: write-first,
  read-first with both register options, no-change, and a base-variant ROM.
  assumes the design files are compiled first.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module test_single_port_sync_block_ram
  import spbr_pkg::*;
;
  localparam logic [7:0] PRESET_V = 8'h5a;
  localparam logic [7:0] INIT_V   = 8'h3c;
  logic       sys_clk_in = 1'b0;
  logic       rst_b_in   = 1'b0;
  logic       gate, we, preset, nd, ready, valid;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, prev_rd, e;
  logic       gate_e, nd_e, prev_v;
  logic       run = 1'b0;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] mem [16];
  logic [7:0] exp_q [$];
  logic [7:0] rd_rf, rd_nc, rd_rom, out_nc, c_rf, s_rf, i_d_rf, e2;
  logic       rdy_rf, rdy_nc, rdy_rom, v_rf, v_nc, v_rom;
  logic       i_w_rf = 1'b0;
  logic [3:0] i_a_rf = 4'h0;
  logic [2:0] vm_rf  = 3'h0;
  logic [2:0] nd_sh  = 3'h0;
  logic [7:0] mem_rf [16];
  logic [7:0] q_rf [$];
  logic [7:0] q_nc [$];
  logic [7:0] q_rom [$];

  always #50 sys_clk_in = ~sys_clk_in;

  spbr_user_model u_user (
    .sys_clk_in (sys_clk_in),
    .gate_out   (gate),
    .we_out     (we),
    .addr_out   (addr),
    .data_out   (wdata),
    .preset_out (preset),
    .nd_out     (nd)
  );

  spbr_top #(.DATA_W(8), .DEPTH(16), .WRITE_MODE(SPBR_WRITE_FIRST),
             .PRESET_VAL(PRESET_V), .INIT_VAL(INIT_V)) DUT (
    .sys_clk_in            (sys_clk_in),
    .rst_b_in              (rst_b_in),
    .port_gate_in          (gate),
    .write_strobe_in       (we),
    .write_data_bus_in     (wdata),
    .word_select_bus_in    (addr),
    .output_sync_preset_in (preset),
    .new_address_valid_in  (nd),
    .read_data_bus_out     (rdata),
    .accept_ready_out      (ready),
    .output_valid_out      (valid)
  );

  spbr_top #(.DATA_W(8), .DEPTH(16), .WRITE_MODE(SPBR_READ_FIRST),
             .REG_INPUTS(1'h1), .OUT_STAGES(1),
             .PRESET_VAL(PRESET_V), .INIT_VAL(INIT_V)) DUT_RF (
    .sys_clk_in            (sys_clk_in),
    .rst_b_in              (rst_b_in),
    .port_gate_in          (gate),
    .write_strobe_in       (we),
    .write_data_bus_in     (wdata),
    .word_select_bus_in    (addr),
    .output_sync_preset_in (preset),
    .new_address_valid_in  (nd),
    .read_data_bus_out     (rd_rf),
    .accept_ready_out      (rdy_rf),
    .output_valid_out      (v_rf)
  );

  spbr_top #(.DATA_W(8), .DEPTH(16), .WRITE_MODE(SPBR_NO_CHANGE),
             .PRESET_VAL(PRESET_V), .INIT_VAL(INIT_V)) DUT_NC (
    .sys_clk_in            (sys_clk_in),
    .rst_b_in              (rst_b_in),
    .port_gate_in          (gate),
    .write_strobe_in       (we),
    .write_data_bus_in     (wdata),
    .word_select_bus_in    (addr),
    .output_sync_preset_in (preset),
    .new_address_valid_in  (nd),
    .read_data_bus_out     (rd_nc),
    .accept_ready_out      (rdy_nc),
    .output_valid_out      (v_nc)
  );

  // base variant: preset value must be zero
  spbr_top #(.DATA_W(8), .DEPTH(16), .ARCH_ADV(1'h0), .IS_ROM(1'h1),
             .PRESET_VAL(8'h00), .INIT_VAL(INIT_V)) DUT_ROM (
    .sys_clk_in            (sys_clk_in),
    .rst_b_in              (rst_b_in),
    .port_gate_in          (gate),
    .write_strobe_in       (we),
    .write_data_bus_in     (wdata),
    .word_select_bus_in    (addr),
    .output_sync_preset_in (preset),
    .new_address_valid_in  (nd),
    .read_data_bus_out     (rd_rom),
    .accept_ready_out      (rdy_rom),
    .output_valid_out      (v_rom)
  );

  // ****************
  // driver and reference
  // ****************
  task automatic op(input logic g, w, input logic [3:0] a, input logic [7:0] d,
                    input logic p, n);
    logic [7:0] x, y, rd;
    x = p ? PRESET_V : (w ? d : mem[a]);
    y = p ? PRESET_V : (w ? out_nc : mem[a]);
    if (g && w) mem[a] = d;
    if (g && n) begin
      exp_q.push_back(x);
      q_nc.push_back(y);
      q_rom.push_back(p ? 8'h00 : INIT_V);
    end
    // read-first build: captured request acts one gated edge later
    if (g) begin
      out_nc = y;
      rd = mem_rf[i_a_rf];
      if (i_w_rf) mem_rf[i_a_rf] = i_d_rf;
      s_rf = p ? PRESET_V : c_rf;
      c_rf = p ? PRESET_V : rd;
      {i_w_rf, i_a_rf, i_d_rf} = {w, a, d};
      vm_rf = {vm_rf[1:0], n};
      if (vm_rf[2]) q_rf.push_back(s_rf);
    end
    u_user.drive(g, w, a, d, p, n);
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************
  // output watcher
  // ****************
  always @(posedge sys_clk_in) begin
    gate_e <= gate;
    nd_e   <= nd;
    if (gate) nd_sh <= {nd_sh[1:0], nd};
  end

  always @(negedge sys_clk_in) begin
    if (rst_b_in && run) begin
      `CHK("ready", gate_e, ready)
      if (gate_e) begin
        `CHK("valid", nd_e, valid)
        if (valid === 1'b1) begin
          if (exp_q.size() == 0) `CHK("queue", 1'b1, 1'b0)
          else begin
            e = exp_q.pop_front();
            `CHK("rdata", e, rdata)
          end
        end
      end else begin
        `CHK("held rdata", prev_rd, rdata)
        `CHK("held valid", prev_v, valid)
      end
    end
    prev_rd <= rdata;
    prev_v  <= valid;
  end

  always @(negedge sys_clk_in) begin
    if (rst_b_in && run && gate_e) begin
      `CHK("rf ready", 1'b1, rdy_rf)
      `CHK("nc ready", 1'b1, rdy_nc)
      `CHK("rom ready", 1'b1, rdy_rom)
      `CHK("rf valid", nd_sh[2], v_rf)
      `CHK("nc valid", nd_e, v_nc)
      `CHK("rom valid", nd_e, v_rom)
      if (v_rf === 1'b1) begin
        if (q_rf.size() == 0) `CHK("rf queue", 1'b1, 1'b0)
        else begin
          e2 = q_rf.pop_front();
          `CHK("rf rdata", e2, rd_rf)
        end
      end
      if (v_nc === 1'b1) begin
        if (q_nc.size() == 0) `CHK("nc queue", 1'b1, 1'b0)
        else begin
          e2 = q_nc.pop_front();
          `CHK("nc rdata", e2, rd_nc)
        end
      end
      if (v_rom === 1'b1) begin
        if (q_rom.size() == 0) `CHK("rom queue", 1'b1, 1'b0)
        else begin
          e2 = q_rom.pop_front();
          `CHK("rom rdata", e2, rd_rom)
        end
      end
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    logic [31:0] r;
    int          i;
    r = $urandom(70);
    foreach (mem[k]) mem[k] = INIT_V;
    foreach (mem_rf[k]) mem_rf[k] = INIT_V;
    c_rf   = PRESET_V;
    s_rf   = PRESET_V;
    out_nc = PRESET_V;
    i_d_rf = 8'h00;
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(negedge sys_clk_in);
    `CHK("reset rdata", PRESET_V, rdata)
    `CHK("reset valid", 1'b0, valid)
    run = 1'b1;
    op(1, 0, 4'h3, 8'h00, 0, 1);
    done("init value");
    // back to back writes show the new word at once
    for (i = 1; i < 5; i++) op(1, 1, i[3:0], 8'h10 + i[7:0], 0, 1);
    for (i = 1; i < 5; i++) op(1, 0, i[3:0], 8'h00, 0, 1);
    done("write read");
    op(1, 1, 4'h5, 8'ha5, 0, 0);
    op(1, 0, 4'h5, 8'h00, 0, 1);
    done("flag off write");
    repeat (3) op(0, 1, 4'h1, 8'hff, 1, 1);
    op(1, 0, 4'h1, 8'h00, 0, 1);
    done("gate closed");
    op(1, 1, 4'h6, 8'h66, 1, 1);
    op(1, 0, 4'h6, 8'h00, 0, 1);
    done("preset with write");
    repeat (80) begin
      r = $urandom;
      op(|r[1:0], r[2], r[7:4], r[15:8], &r[18:16], r[19]);
    end
    // idle gated accesses flush the three-deep read-first pipe
    repeat (4) op(1, 0, 4'h0, 8'h00, 0, 0);
    repeat (3) @(posedge sys_clk_in);
    `CHK("queue drained", 1'b1, exp_q.size() == 0)
    `CHK("other queues drained", 1'b1, q_rf.size() + q_nc.size() + q_rom.size() == 0)
    done("random");
    print_verdict();
  end

  // hang guard, well past the hundred or so accesses above
  initial begin
    #(100 * 1000);
    failures++;
    print_verdict();
  end
endmodule
